// file: hdl/caa_adapter.sv
`timescale 1ns/1ps
// ==========================================================
// Transmit FIFO
module caa_fifo #(
  parameter int WIDTH = caa_pkg::FIFO_W,
  parameter int DEPTH = caa_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clear,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
  logic push, pop;

  // Depth must be a power of two; the extra pointer bit tells full from empty.
  always_comb begin
    in_ready = !((wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
    out_valid = (wr_reg != rd_reg);
    out_data = mem[rd_reg[AW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_next = clear ? '0 : wr_reg + {{AW{1'b0}}, push};
    rd_next = clear ? '0 : rd_reg + {{AW{1'b0}}, pop};
  end

  // Pointers reset; storage needs no reset.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end
endmodule // caa_fifo

// ==========================================================
// Console adapter
module caa_adapter #(
  parameter int TICK_CYCLES = caa_pkg::TICK_CYC,
  parameter int BIT_CYCLES = caa_pkg::BIT_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire caa_pkg::caa_cmd_t cmd,
  output logic cmd_ready,
  output logic [7:0] rx_char,
  output caa_pkg::caa_stat_t stat,
  input wire logic serial_rxd,
  input wire logic dsr_in,
  input wire logic cts_in,
  output logic serial_txd,
  output logic dtr_out,
  output logic rts_out
);
  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam int BW = $clog2(BIT_CYCLES + 1);
  // Synchroniser rest levels {line, set-ready, clear-to-send}: the line idles high, the modem leads low.
  localparam logic [2:0] SYNC_REST = 3'b100;

  // Decodes one command code against the current request.
  function automatic logic hit(input logic v, input caa_pkg::caa_cmd_t c, input logic [7:0] code);
    return v && (c.code == code);
  endfunction

  // Character length from the two-bit field: 0 gives 8 bits, 3 gives 5.
  function automatic logic [3:0] char_bits(input logic [7:0] acr);
    return 4'd8 - {2'b00, acr[caa_pkg::ACR_LEN +: 2]};
  endfunction

  logic [7:0] acr_reg, acr_next, mcr_reg, mcr_next, ast_reg, ast_next, rx_buf_reg, rx_buf_next;
  logic mdm_int_reg, mdm_int_next, tmr_int_reg, tmr_int_next, mck_reg, mck_next;
  logic in_req_reg, in_req_next, dsr_t_reg, dsr_t_next, cts_t_reg, cts_t_next;
  logic dsr_prev_reg, dsr_prev_next, cts_prev_reg, cts_prev_next;
  logic [14:0] tcnt_reg, tcnt_next;
  logic [PW-1:0] pre_reg, pre_next;
  logic trun_reg, trun_next, tmr_fire;
  logic [2:0] sync1_reg, sync2_reg;
  caa_pkg::caa_ser_t tx_st_reg, tx_st_next, rx_st_reg, rx_st_next;
  logic [7:0] tx_sh_reg, tx_sh_next, rx_sh_reg, rx_sh_next;
  logic [3:0] tx_n_reg, tx_n_next, rx_n_reg, rx_n_next;
  logic [BW-1:0] tx_b_reg, tx_b_next, rx_b_reg, rx_b_next;
  logic txd_reg, txd_next, rx_done, rx_brk, rx_line;
  caa_pkg::caa_stat_t stat_next;
  logic adp_rst, wrap, dsr_eff, cts_eff, out_req, exc_req, valid_cmd;
  logic fifo_ready, fifo_valid, fifo_pop;
  logic [7:0] fifo_data;

  // ==========================================================
  // Pin synchronisers: first stage feeds only the second.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= SYNC_REST;
      sync2_reg <= SYNC_REST;
    end else begin
      sync1_reg <= {serial_rxd, dsr_in, cts_in};
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================================
  // Decode of the command port and derived levels.
  always_comb begin
    adp_rst = hit(cmd_valid, cmd, caa_pkg::CMD_ADP_RST);
    valid_cmd = (cmd.code >= caa_pkg::CMD_ACR_SET) && (cmd.code <= caa_pkg::CMD_SENSE);
    wrap = mcr_reg[caa_pkg::MCR_WRAP];
    // In wrap the modem leads loop back inside the adapter.
    dsr_eff = wrap ? mcr_reg[caa_pkg::MCR_DTR] : sync2_reg[1];
    cts_eff = wrap ? (mcr_reg[caa_pkg::MCR_DTR] | mcr_reg[caa_pkg::MCR_RTS] | acr_reg[caa_pkg::ACR_TX])
                   : sync2_reg[0];
    out_req = acr_reg[caa_pkg::ACR_TX] && !fifo_valid && (tx_st_reg == caa_pkg::SER_IDLE);
    exc_req = ast_reg[caa_pkg::AST_OVR] | ast_reg[caa_pkg::AST_INV] | ast_reg[caa_pkg::AST_BRK];
    rx_line = wrap ? txd_reg : sync2_reg[2];
    // A full FIFO refuses a load; the refusal is visible on cmd_ready.
    cmd_ready = !hit(cmd_valid, cmd, caa_pkg::CMD_TX_WR) || fifo_ready;
  end

  // ==========================================================
  // Control and status flags. Hardware sets win over reset-write clears; adapter reset wins over hardware sets.
  always_comb begin
    acr_next = acr_reg;
    mcr_next = mcr_reg;
    ast_next = ast_reg;
    rx_buf_next = rx_buf_reg;
    mck_next = mck_reg;
    in_req_next = in_req_reg;
    mdm_int_next = mdm_int_reg;
    tmr_int_next = tmr_int_reg;
    dsr_t_next = dsr_t_reg;
    cts_t_next = cts_t_reg;
    dsr_prev_next = dsr_eff;
    cts_prev_next = cts_eff;
    if (hit(cmd_valid, cmd, caa_pkg::CMD_ACR_SET)) acr_next = acr_reg | cmd.data;
    if (hit(cmd_valid, cmd, caa_pkg::CMD_ACR_RST)) acr_next = acr_reg & ~cmd.data;
    if (hit(cmd_valid, cmd, caa_pkg::CMD_MCR_WR)) mcr_next = cmd.data;
    if (hit(cmd_valid, cmd, caa_pkg::CMD_RX_RD)) in_req_next = 1'b0;
    if (hit(cmd_valid, cmd, caa_pkg::CMD_AST_RST)) ast_next = ast_reg & ~cmd.data;
    if (hit(cmd_valid, cmd, caa_pkg::CMD_BST_RST)) begin
      if (cmd.data[caa_pkg::BST_MDM]) begin
        mdm_int_next = 1'b0;
        dsr_t_next = 1'b0;
        cts_t_next = 1'b0;
      end
      if (cmd.data[caa_pkg::BST_TMR]) tmr_int_next = 1'b0;
      if (cmd.data[caa_pkg::BST_MCK]) mck_next = 1'b0;
    end
    if (cmd_valid && !valid_cmd) mck_next = 1'b1;
    if (adp_rst) begin
      acr_next = caa_pkg::ZERO8;
      mcr_next = caa_pkg::ZERO8;
      ast_next = caa_pkg::ZERO8;
      in_req_next = 1'b0;
      mdm_int_next = 1'b0;
      tmr_int_next = 1'b0;
      dsr_t_next = 1'b0;
      cts_t_next = 1'b0;
      // Restart edge detection from the pin levels, so the reset itself leaves no transition.
      dsr_prev_next = sync2_reg[1];
      cts_prev_next = sync2_reg[0];
    end else begin
      // Lead changes latch a transition and, unless masked, a modem interrupt.
      if (dsr_eff != dsr_prev_reg) dsr_t_next = 1'b1;
      if (cts_eff != cts_prev_reg) cts_t_next = 1'b1;
      if (((dsr_eff != dsr_prev_reg) || (cts_eff != cts_prev_reg)) && !mcr_reg[caa_pkg::MCR_MDIS]) begin
        mdm_int_next = 1'b1;
      end
      if (tmr_fire) tmr_int_next = 1'b1;
      if (rx_done && acr_reg[caa_pkg::ACR_RX]) begin
        rx_buf_next = rx_sh_reg;
        in_req_next = 1'b1;
        if (in_req_reg && !hit(cmd_valid, cmd, caa_pkg::CMD_RX_RD)) ast_next[caa_pkg::AST_OVR] = 1'b1;
        if (rx_sh_reg == caa_pkg::ZERO8) ast_next[caa_pkg::AST_INV] = 1'b1;
      end
      if (rx_brk && acr_reg[caa_pkg::ACR_RX]) ast_next[caa_pkg::AST_BRK] = 1'b1;
    end
    ast_next[caa_pkg::AST_RCLK] = acr_next[caa_pkg::ACR_RX] && mcr_next[caa_pkg::MCR_WRAP];
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      acr_reg <= caa_pkg::ZERO8;
      mcr_reg <= caa_pkg::ZERO8;
      ast_reg <= caa_pkg::ZERO8;
      rx_buf_reg <= caa_pkg::ZERO8;
      mck_reg <= 1'b0;
      in_req_reg <= 1'b0;
      mdm_int_reg <= 1'b0;
      tmr_int_reg <= 1'b0;
      dsr_t_reg <= 1'b0;
      cts_t_reg <= 1'b0;
      dsr_prev_reg <= 1'b0;
      cts_prev_reg <= 1'b0;
    end else begin
      acr_reg <= acr_next;
      mcr_reg <= mcr_next;
      ast_reg <= ast_next;
      rx_buf_reg <= rx_buf_next;
      mck_reg <= mck_next;
      in_req_reg <= in_req_next;
      mdm_int_reg <= mdm_int_next;
      tmr_int_reg <= tmr_int_next;
      dsr_t_reg <= dsr_t_next;
      cts_t_reg <= cts_t_next;
      dsr_prev_reg <= dsr_prev_next;
      cts_prev_reg <= cts_prev_next;
    end
  end

  // ==========================================================
  // Interval timer: 15-bit count of 0.78 ms ticks, high bit 7 reads as the run
  // flag. High 00 stops, high 80 fires at once, low write clears the high half.
  always_comb begin
    tcnt_next = tcnt_reg;
    trun_next = trun_reg;
    pre_next = pre_reg;
    tmr_fire = 1'b0;
    if (trun_reg) begin
      if (pre_reg == PW'(TICK_CYCLES - 1)) begin
        pre_next = '0;
        tcnt_next = tcnt_reg - 15'd1;
        if (tcnt_reg == 15'd1) begin
          tmr_fire = 1'b1;
          trun_next = 1'b0;
        end
      end else begin
        pre_next = pre_reg + PW'(1);
      end
    end
    if (hit(cmd_valid, cmd, caa_pkg::CMD_TMR_HI)) begin
      pre_next = '0;
      tcnt_next = {cmd.data[6:0], tcnt_reg[7:0]};
      trun_next = (tcnt_next != 15'd0);
      if (cmd.data == caa_pkg::TMR_STOP) trun_next = 1'b0;
      if (cmd.data == caa_pkg::TMR_NOW) begin
        tmr_fire = 1'b1;
        trun_next = 1'b0;
      end
    end
    if (hit(cmd_valid, cmd, caa_pkg::CMD_TMR_LO)) begin
      // Loading the low half drops whatever the high half held.
      pre_next = '0;
      tcnt_next = {7'd0, cmd.data};
      trun_next = (cmd.data != caa_pkg::ZERO8);
    end
    if (adp_rst) begin
      trun_next = 1'b0;
      tcnt_next = 15'd0;
      tmr_fire = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tcnt_reg <= 15'd0;
      pre_reg <= '0;
      trun_reg <= 1'b0;
    end else begin
      tcnt_reg <= tcnt_next;
      pre_reg <= pre_next;
      trun_reg <= trun_next;
    end
  end

  // ==========================================================
  // Transmit buffer. Sixteen deep so software can run ahead of the line.
  caa_fifo #(.WIDTH(caa_pkg::FIFO_W), .DEPTH(caa_pkg::FIFO_DEPTH)) u_txq (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clear(adp_rst),
    .in_data(cmd.data),
    .in_valid(hit(cmd_valid, cmd, caa_pkg::CMD_TX_WR)),
    .in_ready(fifo_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // ==========================================================
  // Serialiser: start bit, data LSB first, one stop bit. Break holds low.
  always_comb begin
    tx_st_next = tx_st_reg;
    tx_sh_next = tx_sh_reg;
    tx_n_next = tx_n_reg;
    tx_b_next = (tx_b_reg == '0) ? '0 : tx_b_reg - BW'(1);
    txd_next = txd_reg;
    fifo_pop = (tx_st_reg == caa_pkg::SER_IDLE) && acr_reg[caa_pkg::ACR_TX] && !adp_rst;
    unique case (tx_st_reg)
      caa_pkg::SER_IDLE: begin
        txd_next = 1'b1;
        if (fifo_pop && fifo_valid) begin
          tx_sh_next = fifo_data;
          tx_n_next = char_bits(acr_reg);
          tx_b_next = BW'(BIT_CYCLES - 1);
          txd_next = 1'b0;
          tx_st_next = caa_pkg::SER_START;
        end
      end
      caa_pkg::SER_START: if (tx_b_reg == '0) begin
        txd_next = tx_sh_reg[0];
        tx_sh_next = tx_sh_reg >> 1;
        tx_n_next = tx_n_reg - 4'd1;
        tx_b_next = BW'(BIT_CYCLES - 1);
        tx_st_next = caa_pkg::SER_DATA;
      end
      caa_pkg::SER_DATA: if (tx_b_reg == '0) begin
        tx_b_next = BW'(BIT_CYCLES - 1);
        if (tx_n_reg == 4'd0) begin
          txd_next = 1'b1;
          tx_st_next = caa_pkg::SER_STOP;
        end else begin
          txd_next = tx_sh_reg[0];
          tx_sh_next = tx_sh_reg >> 1;
          tx_n_next = tx_n_reg - 4'd1;
        end
      end
      caa_pkg::SER_STOP: if (tx_b_reg == '0) tx_st_next = caa_pkg::SER_IDLE;
    endcase
    if (acr_reg[caa_pkg::ACR_BRK]) txd_next = 1'b0;
    if (adp_rst) tx_st_next = caa_pkg::SER_IDLE;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_st_reg <= caa_pkg::SER_IDLE;
      tx_sh_reg <= caa_pkg::ZERO8;
      tx_n_reg <= 4'd0;
      tx_b_reg <= '0;
      txd_reg <= 1'b1;
    end else begin
      tx_st_reg <= tx_st_next;
      tx_sh_reg <= tx_sh_next;
      tx_n_reg <= tx_n_next;
      tx_b_reg <= tx_b_next;
      txd_reg <= txd_next;
    end
  end

  // ==========================================================
  // Receiver: samples mid-bit; a low stop bit after all-zero data is a break, and a low stop bit is never a character.
  always_comb begin
    rx_st_next = rx_st_reg;
    rx_sh_next = rx_sh_reg;
    rx_n_next = rx_n_reg;
    rx_b_next = (rx_b_reg == '0) ? '0 : rx_b_reg - BW'(1);
    rx_done = 1'b0;
    rx_brk = 1'b0;
    unique case (rx_st_reg)
      caa_pkg::SER_IDLE: if (!rx_line) begin
        rx_b_next = BW'(BIT_CYCLES / 2);
        rx_st_next = caa_pkg::SER_START;
      end
      caa_pkg::SER_START: if (rx_b_reg == '0) begin
        rx_b_next = BW'(BIT_CYCLES - 1);
        rx_n_next = char_bits(acr_reg);
        rx_sh_next = caa_pkg::ZERO8;
        rx_st_next = rx_line ? caa_pkg::SER_IDLE : caa_pkg::SER_DATA;
      end
      caa_pkg::SER_DATA: if (rx_b_reg == '0) begin
        rx_b_next = BW'(BIT_CYCLES - 1);
        rx_sh_next = {rx_line, rx_sh_reg[7:1]};
        rx_n_next = rx_n_reg - 4'd1;
        if (rx_n_reg == 4'd1) begin
          // Right-align the shorter characters.
          rx_sh_next = {rx_line, rx_sh_reg[7:1]} >> (4'd8 - char_bits(acr_reg));
          rx_st_next = caa_pkg::SER_STOP;
        end
      end
      caa_pkg::SER_STOP: if (rx_b_reg == '0) begin
        rx_done = rx_line;
        rx_brk = !rx_line && (rx_sh_reg == caa_pkg::ZERO8);
        rx_st_next = caa_pkg::SER_IDLE;
      end
    endcase
    // Receive mode off aborts any frame, so no character can land.
    if (!acr_reg[caa_pkg::ACR_RX] || adp_rst) rx_st_next = caa_pkg::SER_IDLE;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_st_reg <= caa_pkg::SER_IDLE;
      rx_sh_reg <= caa_pkg::ZERO8;
      rx_n_reg <= 4'd0;
      rx_b_reg <= '0;
    end else begin
      rx_st_reg <= rx_st_next;
      rx_sh_reg <= rx_sh_next;
      rx_n_reg <= rx_n_next;
      rx_b_reg <= rx_b_next;
    end
  end

  // ==========================================================
  // Status outputs, registered one cycle behind the internal state.
  always_comb begin
    stat_next.acr = acr_reg;
    stat_next.mcr = mcr_reg;
    stat_next.msr = {4'h0, cts_t_reg, dsr_t_reg, cts_eff, dsr_eff};
    stat_next.ast = ast_reg;
    stat_next.bst = {1'b0, mck_reg,
                     mdm_int_reg | tmr_int_reg | out_req | in_req_reg | exc_req | mck_reg,
                     exc_req, in_req_reg, out_req, tmr_int_reg, mdm_int_reg};
    stat_next.tmr_hi = {trun_reg, tcnt_reg[14:8]};
    stat_next.tmr_lo = tcnt_reg[7:0];
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stat <= '0;
      rx_char <= caa_pkg::ZERO8;
      serial_txd <= 1'b1;
      dtr_out <= 1'b0;
      rts_out <= 1'b0;
    end else begin
      stat <= stat_next;
      rx_char <= rx_buf_reg;
      serial_txd <= txd_reg;
      dtr_out <= mcr_reg[caa_pkg::MCR_DTR];
      rts_out <= mcr_reg[caa_pkg::MCR_RTS];
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_wrap_dtr_up;
    wrap && !mcr_reg[caa_pkg::MCR_MDIS] && $rose(mcr_reg[caa_pkg::MCR_DTR]) && !adp_rst
      && !mcr_reg[caa_pkg::MCR_RTS] && !acr_reg[caa_pkg::ACR_TX];
  endsequence

  a_wrap_both_trans: assert property (s_wrap_dtr_up |=> dsr_t_reg && cts_t_reg && mdm_int_reg)
    else $error("wrap with terminal-ready lacked transitions");
  a_dtr_drop_trans: assert property (wrap && $fell(mcr_reg[caa_pkg::MCR_DTR]) && !adp_rst |=> dsr_t_reg)
    else $error("terminal-ready drop gave no transition");
  a_tx_cts_trans: assert property (wrap && !mcr_reg[caa_pkg::MCR_DTR] && !mcr_reg[caa_pkg::MCR_RTS]
    && $rose(acr_reg[caa_pkg::ACR_TX]) && !adp_rst |=> cts_t_reg)
    else $error("transmit mode gave no clear-to-send transition");
  a_modem_int_clr: assert property (hit(cmd_valid, cmd, caa_pkg::CMD_BST_RST) && cmd.data[caa_pkg::BST_MDM]
    && dsr_eff == dsr_prev_reg && cts_eff == cts_prev_reg |=> !mdm_int_reg)
    else $error("modem interrupt not cleared");
  a_modem_masked: assert property (mcr_reg[caa_pkg::MCR_MDIS] && !mdm_int_reg |=> !mdm_int_reg)
    else $error("masked modem interrupt was raised");
  a_timer_stop: assert property (hit(cmd_valid, cmd, caa_pkg::CMD_TMR_HI) && cmd.data == caa_pkg::TMR_STOP
    |=> !trun_reg ##1 !tmr_fire)
    else $error("timer kept running after stop");
  a_timer_now: assert property (hit(cmd_valid, cmd, caa_pkg::CMD_TMR_HI) && cmd.data == caa_pkg::TMR_NOW
    && !adp_rst |=> tmr_int_reg ##1 stat.bst[caa_pkg::BST_TMR])
    else $error("immediate timeout not flagged");
  a_outreq_load: assert property (out_req && hit(cmd_valid, cmd, caa_pkg::CMD_TX_WR) |=> !out_req)
    else $error("output request stayed after load");
  a_no_inreq: assert property (!acr_reg[caa_pkg::ACR_RX] && !in_req_reg |=> !in_req_reg)
    else $error("input request with receive off");
  a_overrun_set: assert property (rx_done && acr_reg[caa_pkg::ACR_RX] && in_req_reg && !cmd_valid
    |=> ast_reg[caa_pkg::AST_OVR] && in_req_reg)
    else $error("overrun not flagged");
  a_acr_set_or: assert property (hit(cmd_valid, cmd, caa_pkg::CMD_ACR_SET)
    |=> acr_reg == ($past(acr_reg) | $past(cmd.data)))
    else $error("control register set is not an OR");
  a_bad_cmd_mck: assert property (cmd_valid && !valid_cmd |=> mck_reg ##1 stat.bst[caa_pkg::BST_MCK])
    else $error("invalid command gave no machine check");

endmodule // caa_adapter

// file: shared/caa_pkg.sv
// Overview of operation
// - Wrap plus terminal-ready flags both transitions, interrupt
// - Dropping terminal-ready in wrap flags set-ready transition
// - Transmit mode in wrap flags clear-to-send transition
// - Modem interrupt clears by reset write
// - Control bit disables modem interrupts
// - 1.6 ms load fires between 1.4 and 1.8 ms
// - 0.2 s load fires between 180 and 220 ms
// - Timer high all ones starts 25 s timer
// - Timer low 01 clears high, fires within 1 ms
// - Timer low 01 from idle runs 0.78 ms
// - Timer high zero stops the timer
// - Timer high 80 hex times out at once
// - Timer interrupt clears by reset write
// - Empty transmit buffer raises output request; load clears
// - Receive clock shown running in wrap receive
// - Wrapped character arrives intact; read clears input request
// - No new input request while receive mode off
// - Unread character overwritten sets clearable overrun
// - All-zero character sets clearable invalid bit
// - Receive plus break in wrap sets break bit
// - Character length 8, 7, 6 or 5 bits
// - Terminal-ready, request-to-send, wrap give modem interrupt
// - Control register resets zero, set/reset commands OR/clear
// - Unknown command sets clearable machine check
package caa_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_NS = 25;
  localparam int TICK_NS = 780000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int BIT_CYC = 16;
  localparam int FIFO_W = 8;
  localparam int FIFO_DEPTH = 16;

  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_ACR_SET = 8'h01;
  localparam logic [7:0] CMD_ACR_RST = 8'h02;
  localparam logic [7:0] CMD_MCR_WR = 8'h03;
  localparam logic [7:0] CMD_TMR_HI = 8'h04;
  localparam logic [7:0] CMD_TMR_LO = 8'h05;
  localparam logic [7:0] CMD_TX_WR = 8'h06;
  localparam logic [7:0] CMD_RX_RD = 8'h07;
  localparam logic [7:0] CMD_BST_RST = 8'h08;
  localparam logic [7:0] CMD_AST_RST = 8'h09;
  localparam logic [7:0] CMD_ADP_RST = 8'h0A;
  localparam logic [7:0] CMD_SENSE = 8'h0B;

  // ==========================================================
  // Field positions and special values
  localparam int ACR_TX = 0;
  localparam int ACR_RX = 1;
  localparam int ACR_BRK = 2;
  localparam int ACR_LEN = 3;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_WRAP = 2;
  localparam int MCR_MDIS = 3;
  localparam int MSR_DSR = 0;
  localparam int MSR_CTS = 1;
  localparam int MSR_DSR_T = 2;
  localparam int MSR_CTS_T = 3;
  localparam int AST_OVR = 0;
  localparam int AST_INV = 1;
  localparam int AST_BRK = 2;
  localparam int AST_RCLK = 3;
  localparam int BST_MDM = 0;
  localparam int BST_TMR = 1;
  localparam int BST_OUT = 2;
  localparam int BST_IN = 3;
  localparam int BST_EXC = 4;
  localparam int BST_IRQ = 5;
  localparam int BST_MCK = 6;
  localparam int TMR_RUN_BIT = 7;
  localparam logic [7:0] TMR_STOP = 8'h00;
  localparam logic [7:0] TMR_NOW = 8'h80;
  localparam logic [7:0] ZERO8 = 8'h00;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] data;
  } caa_cmd_t;

  typedef struct packed {
    logic [7:0] acr;
    logic [7:0] mcr;
    logic [7:0] msr;
    logic [7:0] ast;
    logic [7:0] bst;
    logic [7:0] tmr_hi;
    logic [7:0] tmr_lo;
  } caa_stat_t;

  typedef enum logic [3:0] {
    SER_IDLE = 4'b0001,
    SER_START = 4'b0010,
    SER_DATA = 4'b0100,
    SER_STOP = 4'b1000
  } caa_ser_t;

endpackage

// file: tb/caa_line_model.sv
`timescale 1ns/1ps
// ==========
// Line partner
// A wrap plug on the line. Leads follow the adapter: set-ready echoes terminal-ready, clear-to-send echoes request-to-send.
module caa_line_model (
  input wire logic serial_txd,
  input wire logic dtr_out,
  input wire logic rts_out,
  output logic serial_rxd,
  output logic dsr_in,
  output logic cts_in
);
  // Echo the line. The line rests high while the adapter idles.
  assign serial_rxd = serial_txd;
  assign dsr_in = dtr_out;
  assign cts_in = rts_out;
endmodule // caa_line_model

// file: tb/console_async_adapter_bench.sv
`timescale 1ns/1ps
// ==========
// Bench
module console_async_adapter_bench;
  logic clk_sys;
  logic rstn;
  logic cmd_valid;
  logic cmd_ready;
  caa_pkg::caa_cmd_t cmd;
  logic [7:0] rx_char;
  caa_pkg::caa_stat_t stat;
  logic serial_rxd, dsr_in, cts_in, serial_txd, dtr_out, rts_out;
  int n_mismatch = 0;
  int checked = 0;
  int seed = 39;
  int k;
  logic [7:0] ch;
  // Short tick and bit time keep the run brief.
  caa_adapter #(.TICK_CYCLES(20), .BIT_CYCLES(4)) i_caa_adapter (.clk_sys(clk_sys), .rstn(rstn),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rx_char(rx_char), .stat(stat), .serial_rxd(serial_rxd),
    .dsr_in(dsr_in), .cts_in(cts_in), .serial_txd(serial_txd), .dtr_out(dtr_out), .rts_out(rts_out));
  caa_line_model i_caa_line_model (.serial_txd(serial_txd), .dtr_out(dtr_out), .rts_out(rts_out),
    .serial_rxd(serial_rxd), .dsr_in(dsr_in), .cts_in(cts_in));
  // Clock at 40 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Compare and count.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict.
  task automatic finish_test();
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One command for a single taking edge, held until cmd_ready; returns once stat shows the effect.
  task automatic send(input logic [7:0] code, input logic [7:0] data);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd.code = code;
    cmd.data = data;
    #1;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 40) begin
      @(negedge clk_sys);
      k++;
    end
    if (k == 40) begin
      n_mismatch++;
      finish_test();
    end
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  // Bounded wait on a basic status bit; a hang ends the run.
  task automatic wait_bst(input int b);
    k = 0;
    while (stat.bst[b] !== 1'b1 && k < 400) begin
      @(negedge clk_sys);
      k++;
    end
    if (k == 400) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  // Main sequence.
  initial begin
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    repeat (5) @(negedge clk_sys);
    rstn = 1'b1;
    check(stat.acr, 8'h00);
    send(caa_pkg::CMD_ACR_SET, 8'h55); check(stat.acr, 8'h55);
    send(caa_pkg::CMD_ACR_SET, 8'hAA); check(stat.acr, 8'hFF);
    send(caa_pkg::CMD_ACR_RST, 8'h55); check(stat.acr, 8'hAA);
    send(caa_pkg::CMD_ACR_RST, 8'hAA); check(stat.acr, 8'h00);
    // Unknown codes, both extremes and random ones.
    for (int i = 0; i < 5; i++) begin
      ch = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'h0C + 8'($unsigned($random(seed)) % 244);
      send(ch, 8'($random(seed)));
      check(stat.bst & 8'h40, 8'h40);
      send(caa_pkg::CMD_BST_RST, 8'h40); check(stat.bst & 8'h40, 8'h00);
    end
    send(caa_pkg::CMD_MCR_WR, 8'h05); check(stat.msr & 8'h0C, 8'h0C);
    check(stat.mcr, 8'h05);
    check({6'd0, rts_out, dtr_out}, 8'h01);
    check(stat.bst & 8'h21, 8'h21);
    send(caa_pkg::CMD_BST_RST, 8'h01); check(stat.bst & 8'h21, 8'h00);
    send(caa_pkg::CMD_MCR_WR, 8'h04); check(stat.bst & 8'h01, 8'h01);
    check(stat.msr & 8'h04, 8'h04);
    send(caa_pkg::CMD_BST_RST, 8'h01);
    send(caa_pkg::CMD_MCR_WR, 8'h0C);
    send(caa_pkg::CMD_MCR_WR, 8'h0D); check(stat.bst & 8'h01, 8'h00);
    send(caa_pkg::CMD_ADP_RST, 8'h00); check(stat.acr, 8'h00);
    send(caa_pkg::CMD_MCR_WR, 8'h04); check(stat.msr & 8'h08, 8'h00);
    send(caa_pkg::CMD_ACR_SET, 8'h01); check(stat.msr & 8'h08, 8'h08);
    send(caa_pkg::CMD_ADP_RST, 8'h00);
    send(caa_pkg::CMD_TMR_HI, 8'h80); check(stat.bst & 8'h02, 8'h02);
    send(caa_pkg::CMD_BST_RST, 8'h02); check(stat.bst & 8'h02, 8'h00);
    send(caa_pkg::CMD_TMR_LO, 8'h01);
    repeat (14) @(negedge clk_sys);
    check(stat.bst & 8'h02, 8'h00);
    repeat (10) @(negedge clk_sys);
    check(stat.bst & 8'h02, 8'h02);
    send(caa_pkg::CMD_BST_RST, 8'h02);
    send(caa_pkg::CMD_TMR_LO, 8'h01);
    send(caa_pkg::CMD_TMR_HI, 8'h00);
    repeat (40) @(negedge clk_sys);
    check(stat.bst & 8'h02, 8'h00);
    send(caa_pkg::CMD_TMR_HI, 8'hFF);
    check(stat.tmr_hi, 8'hFF);
    send(caa_pkg::CMD_TMR_LO, 8'h01);
    check(stat.tmr_hi, 8'h80);
    check(stat.tmr_lo, 8'h01);
    repeat (23) @(negedge clk_sys);
    check(stat.bst & 8'h02, 8'h02);
    // Sixteen loads fill the buffer while transmit mode is off; a seventeenth is refused.
    send(caa_pkg::CMD_ADP_RST, 8'h00);
    for (int i = 0; i < 16; i++) send(caa_pkg::CMD_TX_WR, 8'($random(seed)));
    check(stat.bst & 8'h04, 8'h00);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd.code = caa_pkg::CMD_TX_WR;
    @(negedge clk_sys);
    check({7'd0, cmd_ready}, 8'h00);
    cmd_valid = 1'b0;
    // Wrapped characters at each length, with random data.
    for (int i = 0; i < 4; i++) begin
      ch = 8'($random(seed)) | 8'h01;
      send(caa_pkg::CMD_ADP_RST, 8'h00);
      send(caa_pkg::CMD_MCR_WR, 8'h04);
      send(caa_pkg::CMD_TX_WR, ch);
      send(caa_pkg::CMD_ACR_SET, 8'(i << 3) | 8'h03);
      wait_bst(caa_pkg::BST_IN);
      check(rx_char, ch & (8'hFF >> i));
      check(stat.ast & 8'h08, 8'h08);
      send(caa_pkg::CMD_RX_RD, 8'h00); check(stat.bst & 8'h0C, 8'h04);
      send(caa_pkg::CMD_TX_WR, ch); check(stat.bst & 8'h04, 8'h00);
    end
    // A second unread character overruns the first.
    wait_bst(caa_pkg::BST_IN);
    send(caa_pkg::CMD_TX_WR, 8'h01);
    repeat (80) @(negedge clk_sys);
    check(stat.ast & 8'h01, 8'h01);
    check(stat.bst & 8'h30, 8'h30);
    send(caa_pkg::CMD_AST_RST, 8'h01); check(stat.ast & 8'h01, 8'h00);
    // Transmit only: the wrapped character must not raise an input request.
    send(caa_pkg::CMD_ADP_RST, 8'h00);
    send(caa_pkg::CMD_MCR_WR, 8'h04);
    send(caa_pkg::CMD_TX_WR, 8'h55);
    send(caa_pkg::CMD_ACR_SET, 8'h01);
    repeat (80) @(negedge clk_sys);
    check(stat.bst & 8'h08, 8'h00);
    check(stat.ast & 8'h08, 8'h00);
    // An all-zero character is flagged invalid.
    send(caa_pkg::CMD_ADP_RST, 8'h00);
    send(caa_pkg::CMD_MCR_WR, 8'h04);
    send(caa_pkg::CMD_TX_WR, 8'h00);
    send(caa_pkg::CMD_ACR_SET, 8'h03);
    wait_bst(caa_pkg::BST_IN);
    check(stat.ast & 8'h02, 8'h02);
    check(stat.bst & 8'h30, 8'h30);
    send(caa_pkg::CMD_AST_RST, 8'h02);
    check(stat.ast & 8'h02, 8'h00);
    // Break held on the wrapped line; the line is released before the bit is cleared.
    send(caa_pkg::CMD_ADP_RST, 8'h00);
    send(caa_pkg::CMD_MCR_WR, 8'h04);
    send(caa_pkg::CMD_ACR_SET, 8'h06);
    repeat (60) @(negedge clk_sys);
    check(stat.ast & 8'h04, 8'h04);
    check(stat.bst & 8'h30, 8'h30);
    send(caa_pkg::CMD_ACR_RST, 8'h04);
    send(caa_pkg::CMD_AST_RST, 8'h04);
    check(stat.ast & 8'h04, 8'h00);
    finish_test();
  end
endmodule // console_async_adapter_bench
